// File: rtl/sfp_pkg.sv
// Purpose: Shared constants and types for the port forwarding policy block
// Assumes: 9 ports, 32-bit AXI4-Lite register access
// Notes:   All offsets are byte addresses of aligned words
package sfp_pkg;

  localparam int NPORT     = 9;
  localparam int PW        = 4;
  localparam int VID_LSB   = 4;
  localparam int VID_MSB   = 6;
  localparam int FIFO_W    = 32;
  localparam int FIFO_D    = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_PORT0   = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h40;
  localparam logic [7:0] OFS_MIRROR  = 8'h44;
  localparam logic [7:0] OFS_RATE    = 8'h48;
  localparam logic [7:0] OFS_SLEEP   = 8'h4C;
  localparam logic [7:0] OFS_IDLE    = 8'h50;

  localparam logic [7:0]  PORT_CTRL_RST = 8'h00;
  localparam logic [15:0] IDLE_RST      = 16'h0100;

  // Mirror pins: bit 3 direction, bits 2:0 port, 3'h7 disables
  localparam int          MIR_DIR_BIT = 3;
  localparam logic [2:0]  MIR_OFF     = 3'h7;
  localparam logic [3:0]  MIR_PORT    = 4'h7;
  localparam logic [3:0]  CASC_PORT   = 4'h8;

  // Cascade rate multiplier from straps, in 100 Mbps units
  localparam logic [2:0] RATE_X1 = 3'h1;
  localparam logic [2:0] RATE_X2 = 3'h2;
  localparam logic [2:0] RATE_X3 = 3'h3;
  localparam logic [2:0] RATE_X4 = 3'h4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] { ST_RUN, ST_STRAP } sfp_mode_t;

  typedef struct packed {
    logic [PW-1:0] src_port;
    logic [47:0]   src_mac;
    logic [47:0]   dst_mac;
    logic [PW-1:0] learned_port;
    logic          learned_hit;
  } sfp_pkt_t;

  typedef struct packed {
    logic [NPORT-1:0] fwd_mask;
    logic             relearn;
    logic [PW-1:0]    relearn_port;
  } sfp_dec_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } sfp_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } sfp_axi_rsp_t;

endpackage : sfp_pkg

// File: rtl/sfp_fifo.sv
// Purpose: Decision FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes:   Depth must be a power of two
`timescale 1ns/100ps
module sfp_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  // Clock, reset and enable
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // Fill side
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sfp_fifo_st_t;

  sfp_fifo_st_t s_q, s_d;
  logic [W-1:0] mem [D];
  logic         full, empty, push, pop;

  assign empty     = s_q.wp == s_q.rp;
  assign full      = (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]) &&
                     (s_q.wp[AW] != s_q.rp[AW]);
  // Enable low shuts both sides so no item is lost while frozen
  assign in_ready  = !full && ce;
  assign out_valid = !empty && ce;
  assign push      = in_valid && !full && ce;
  assign pop       = out_ready && !empty && ce;
  assign out_data  = mem[s_q.rp[AW-1:0]];

  always_comb begin
    s_d = s_q;
    if (push) s_d.wp = s_q.wp + 1'b1;
    if (pop)  s_d.rp = s_q.rp + 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Storage needs no reset; read only behind valid
  always_ff @(posedge aclk) begin
    if (push) mem[s_q.wp[AW-1:0]] <= in_data;
  end
endmodule : sfp_fifo

// File: rtl/sfp_policy.sv
// Purpose: Forwarding policy of a 9-port switch: VLAN, trunk, mirror,
//          MAC sleep, cascade straps
// Assumes: 50 MHz aclk, synchronous pins, AXI4-Lite register access
// Notes:   Decisions leave through a 16-word FIFO
//
// Functional notes
// - Each of nine ports keeps a 3-bit VLAN id in control bits 6:4.
// - Forward only to other ports whose VLAN id equals the source's.
// - Trunk pin high makes ports 0 and 1 one logical port.
// - Trunk source address stored on a non-member port is relearned.
// - Trunk member chosen by hash of source and destination address.
// - A trunk member with link down hands all traffic to the other.
// - Mirror pins: bit 3 rx/tx, bits 2:0 port, all ones disables.
// - While enabled, chosen direction of mirrored port is copied to 7.
// - Floating mirror pins behave as mirroring disabled.
// - A MAC sleeps when its port neither receives nor transmits.
// - Data written to a transmit FIFO wakes the MAC at once.
// - CRS_DV assertion wakes the MAC and the frame is received.
// - Straps at reset set cascade rate: 11,10,01,00 = 100..400 Mbps.
// - Cascade rate comes from multiplying its reference clock.
// - Cascade port is an ordinary output with standard frames.
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
module sfp_policy
  import sfp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  // Register bus
  input  wire sfp_axi_req_t       axi_req,
  output      sfp_axi_rsp_t       axi_rsp,
  // Pins
  input  wire logic               trunk_en,
  input  wire logic [3:0]         mirror_select_pins,
  input  wire logic [1:0]         rate_straps,
  input  wire logic [NPORT-1:0]   link_up,
  input  wire logic [NPORT-1:0]   crs_dv,
  input  wire logic [NPORT-1:0]   tx_active,
  input  wire logic [NPORT-1:0]   txfifo_wr,
  // Packet lookup request
  input  wire logic               pkt_valid,
  output      logic               pkt_ready,
  input  wire sfp_pkt_t           pkt,
  // Forwarding decisions out
  output      logic               dec_valid,
  input  wire logic               dec_ready,
  output      sfp_dec_t           dec,
  // MAC and cascade control
  output      logic [NPORT-1:0]   mac_awake,
  output      logic [2:0]         casc_mult
);

  typedef struct packed {
    logic [NPORT-1:0][7:0]  port_ctrl;
    logic [NPORT-1:0]       asleep;
    logic [NPORT-1:0][15:0] idle_cnt;
    logic [15:0]            idle_lim;
    logic [2:0]             mult;
    sfp_mode_t              mode;
    logic                   aw_got;
    logic                   w_got;
    logic [7:0]             awaddr;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } sfp_st_t;

  sfp_st_t s_q, s_d;

  function automatic logic [2:0] vid_of(input logic [7:0] c);
    return c[VID_MSB:VID_LSB];
  endfunction : vid_of

  function automatic logic hash_bit(input logic [47:0] a,
                                    input logic [47:0] b);
    return ^(a ^ b);
  endfunction : hash_bit

  function automatic logic [2:0] rate_mult(input logic [1:0] s);
    case (s)
      2'b11:   return RATE_X1;
      2'b10:   return RATE_X2;
      2'b01:   return RATE_X3;
      default: return RATE_X4;
    endcase
  endfunction : rate_mult

  // Mirror decode; floating pins are expected pulled to ones
  logic       mir_on, mir_rx;
  logic [2:0] mir_port;
  assign mir_port = mirror_select_pins[2:0];
  assign mir_rx   = mirror_select_pins[MIR_DIR_BIT];
  assign mir_on   = mir_port != MIR_OFF;

  // Forwarding decision
  sfp_dec_t         d_new;
  logic [2:0]       svid;
  logic             src_trunk, pick1;
  logic [NPORT-1:0] mask;
  always_comb begin
    mask      = '0;
    svid      = vid_of(s_q.port_ctrl[pkt.src_port]);
    src_trunk = trunk_en && (pkt.src_port < 4'h2);
    for (int i = 0; i < NPORT; i++) begin
      // Cascade port is handled like any other output
      mask[i] = (vid_of(s_q.port_ctrl[i]) == svid) &&
                (PW'(i) != pkt.src_port);
    end
    if (trunk_en) begin
      if (src_trunk) mask[1:0] = 2'b00;
      pick1 = hash_bit(pkt.src_mac, pkt.dst_mac);
      if (!link_up[0]) pick1 = 1'b1;
      else if (!link_up[1]) pick1 = 1'b0;
      if (mask[0] || mask[1]) begin
        mask[0] = !pick1;
        mask[1] = pick1;
      end
    end else begin
      pick1 = 1'b0; // Ports stay independent
    end
    // Receive mirroring copies from the source side
    if (mir_on && mir_rx && pkt.src_port == PW'(mir_port))
      mask[MIR_PORT] = 1'b1;
    if (mir_on && !mir_rx && pkt.src_port != PW'(mir_port) &&
        mask[mir_port])
      mask[MIR_PORT] = 1'b1;
    d_new.fwd_mask     = mask;
    d_new.relearn      = src_trunk && pkt.learned_hit &&
                         (pkt.learned_port > 4'h1);
    d_new.relearn_port = pkt.src_port;
    if (!trunk_en)
      d_new.relearn = 1'b0;
  end

  sfp_fifo #(.W($bits(sfp_dec_t)), .D(FIFO_D)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .in_valid  (pkt_valid),
    .in_ready  (pkt_ready),
    .in_data   (d_new),
    .out_valid (dec_valid),
    .out_ready (dec_ready),
    .out_data  (dec)
  );

  // Register bus
  logic        wr_fire, rd_fire, aw_hs, w_hs;
  logic [7:0]  raddr;
  logic [31:0] rword;
  logic        rhit;

  // Handshakes gated by enable; a frozen cycle must not accept a transfer
  assign aw_hs   = axi_req.awvalid && !s_q.aw_got && !s_q.bvalid && ce;
  assign w_hs    = axi_req.wvalid && !s_q.w_got && !s_q.bvalid && ce;
  assign wr_fire = (s_q.aw_got || aw_hs) && (s_q.w_got || w_hs);
  assign rd_fire = axi_req.arvalid && !s_q.rvalid && ce;
  assign raddr   = axi_req.araddr[7:0];

  always_comb begin
    rword = '0;
    rhit  = 1'b1;
    if (raddr < OFS_STATUS && raddr[1:0] == 2'b00 &&
        raddr[7:2] < 6'(NPORT))
      rword[7:0] = s_q.port_ctrl[raddr[5:2]];
    else case (raddr)
      OFS_STATUS: rword[NPORT-1:0] = link_up;
      OFS_MIRROR: rword[5:0] = {mir_on, mir_rx, mirror_select_pins};
      OFS_RATE:   rword[2:0] = s_q.mult;
      OFS_SLEEP:  rword[NPORT-1:0] = s_q.asleep;
      OFS_IDLE:   rword[15:0] = s_q.idle_lim;
      default:    rhit = 1'b0;
    endcase
  end

  always_comb begin
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        whit;
    s_d  = s_q;
    wa   = s_q.aw_got ? s_q.awaddr : axi_req.awaddr[7:0];
    wd   = s_q.w_got ? s_q.wdata : axi_req.wdata;
    ws   = s_q.w_got ? s_q.wstrb : axi_req.wstrb;
    whit = 1'b0;
    if (s_q.mode == ST_STRAP) begin
      s_d.mult = rate_mult(rate_straps);
      s_d.mode = ST_RUN;
    end
    if (aw_hs) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = axi_req.awaddr[7:0];
    end
    if (w_hs) begin
      s_d.w_got = 1'b1;
      s_d.wdata = axi_req.wdata;
      s_d.wstrb = axi_req.wstrb;
    end
    if (wr_fire) begin
      if (wa < OFS_STATUS && wa[1:0] == 2'b00 && wa[7:2] < 6'(NPORT)) begin
        whit = 1'b1;
        if (ws[0]) s_d.port_ctrl[wa[5:2]] = wd[7:0];
      end else if (wa == OFS_IDLE) begin
        whit = 1'b1;
        if (ws[0]) s_d.idle_lim[7:0]  = wd[7:0];
        if (ws[1]) s_d.idle_lim[15:8] = wd[15:8];
      end else if (wa == OFS_STATUS || wa == OFS_MIRROR ||
                   wa == OFS_RATE || wa == OFS_SLEEP) begin
        whit = 1'b1;
      end
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = whit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.bvalid && axi_req.bready) s_d.bvalid = 1'b0;
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rword;
      s_d.rresp  = rhit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.rvalid && axi_req.rready) s_d.rvalid = 1'b0;
    // MAC sleep: wake wins over idle timeout
    for (int i = 0; i < NPORT; i++) begin
      if (crs_dv[i] || txfifo_wr[i]) begin
        s_d.asleep[i]   = 1'b0;
        s_d.idle_cnt[i] = '0;
      end else if (tx_active[i]) begin
        s_d.idle_cnt[i] = '0;
      end else if (!s_q.asleep[i]) begin
        if (s_q.idle_cnt[i] >= s_q.idle_lim)
          s_d.asleep[i] = 1'b1;
        else
          s_d.idle_cnt[i] = s_q.idle_cnt[i] + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q           <= '0;
      s_q.port_ctrl <= {NPORT{PORT_CTRL_RST}};
      s_q.idle_lim  <= IDLE_RST;
      s_q.mode      <= ST_STRAP;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign axi_rsp.awready = aw_hs;
  assign axi_rsp.wready  = w_hs;
  assign axi_rsp.bvalid  = s_q.bvalid;
  assign axi_rsp.bresp   = s_q.bresp;
  assign axi_rsp.arready = rd_fire;
  assign axi_rsp.rvalid  = s_q.rvalid;
  assign axi_rsp.rdata   = s_q.rdata;
  assign axi_rsp.rresp   = s_q.rresp;
  // Wake requests show at once, before the register catches up
  assign mac_awake = ~s_q.asleep | crs_dv | txfifo_wr;
  assign casc_mult = s_q.mult;
endmodule : sfp_policy

// File: test/sfp_phy_model.sv
// Purpose: Far side stand-in: PHY activity, link status, decision sink
// Assumes: Bench raises requests; model re-times them on aclk
// Notes:   Stall stops the sink, as a busy output queue would
`timescale 1ns/100ps
module sfp_phy_model
  import sfp_pkg::*;
(
  // Clock
  input  wire logic             aclk,
  // Bench requests
  input  wire logic             stall,
  input  wire logic [NPORT-1:0] link_cfg,
  input  wire logic [NPORT-1:0] rx_req,
  input  wire logic [NPORT-1:0] tx_req,
  input  wire logic [NPORT-1:0] wr_req,
  // Toward the block
  output      logic             dec_ready,
  output      logic [NPORT-1:0] link_up,
  output      logic [NPORT-1:0] crs_dv,
  output      logic [NPORT-1:0] tx_active,
  output      logic [NPORT-1:0] txfifo_wr
);
  initial {dec_ready, link_up, crs_dv, tx_active, txfifo_wr} = '0;
  always @(posedge aclk) begin
    dec_ready <= !stall;
    link_up   <= link_cfg;
    crs_dv    <= rx_req;
    tx_active <= tx_req;
    txfifo_wr <= wr_req;
  end
endmodule : sfp_phy_model

// File: test/sfp_policy_assertions.sv
// Purpose: Port-level checks of the forwarding policy block
// Assumes: ce held high, straps steady after each reset
// Notes:   A push into an empty queue makes the next head inspectable
`timescale 1ns/100ps
module sfp_policy_chk
  import sfp_pkg::*;
(
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             trunk_en,
  input wire logic [3:0]       mirror_select_pins,
  input wire logic [1:0]       rate_straps,
  input wire logic [NPORT-1:0] link_up,
  input wire logic [NPORT-1:0] crs_dv,
  input wire logic [NPORT-1:0] txfifo_wr,
  input wire logic             pkt_valid,
  input wire logic             pkt_ready,
  input wire sfp_pkt_t         pkt,
  input wire logic             dec_valid,
  input wire logic             dec_ready,
  input wire sfp_dec_t         dec,
  input wire logic [NPORT-1:0] mac_awake,
  input wire logic [2:0]       casc_mult
);
  wire logic fresh = pkt_valid && pkt_ready && !dec_valid;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_casc_rate: assert property (
    $past(aresetn) && $past(aresetn, 2) |->
    casc_mult == 3'h4 - {1'b0, rate_straps}) else $error("bad cascade rate");
  chk_no_self: assert property (
    fresh && pkt.src_port != MIR_PORT |=>
    dec_valid && !dec.fwd_mask[$past(pkt.src_port)]) else $error("echo");
  chk_trunk_back: assert property (
    fresh && trunk_en && pkt.src_port < 4'h2 |=> dec.fwd_mask[1:0] == 2'h0)
    else $error("trunk echo");
  chk_trunk_one: assert property (
    fresh && trunk_en |=> dec.fwd_mask[1:0] != 2'h3) else $error("two members");
  chk_link_failover: assert property (
    fresh && trunk_en && link_up[1:0] != 2'h0 |=>
    (dec.fwd_mask[1:0] & ~$past(link_up[1:0])) == 2'h0) else $error("dead link");
  chk_relearn_set: assert property (
    fresh && trunk_en && pkt.learned_hit && pkt.learned_port > 4'h1 &&
    pkt.src_port < 4'h2 |=> dec.relearn) else $error("no relearn");
  chk_relearn_off: assert property (
    fresh && !trunk_en |=> !dec.relearn) else $error("relearn untrunked");
  chk_mirror_rx: assert property (
    fresh && mirror_select_pins[3] && mirror_select_pins[2:0] != MIR_OFF &&
    pkt.src_port == {1'b0, mirror_select_pins[2:0]} |=> dec.fwd_mask[7])
    else $error("rx not mirrored");
  chk_wake_now: assert property (
    ((crs_dv | txfifo_wr) & ~mac_awake) == '0) else $error("wake missed");
  chk_dec_hold: assert property (
    dec_valid && !dec_ready |=> dec_valid && $stable(dec)) else $error("drop");
  cover property (fresh && trunk_en);
  cover property (!pkt_ready);
  cover property ($fell(mac_awake[0]));
endmodule : sfp_policy_chk
bind sfp_policy sfp_policy_chk sfp_policy_chk_inst (.*);

// File: test/sfp_policy_tb_top.sv
// Purpose: Register, lookup, queue and sleep tests of the policy block
// Assumes: ce high except in the enable test; one lookup in flight except in the fill test
// Notes:   Expected masks come from a small reference of the rules
`timescale 1ns/100ps
module sfp_policy_tb_top
  import sfp_pkg::*;
;
  logic aclk, aresetn, trunk_en, stall, pv, pkt_ready, dec_valid, dec_ready;
  logic ce;
  logic [3:0]  mirror_select_pins;
  logic [1:0]  rate_straps;
  logic [8:0]  link_cfg, rx_req, tx_req, wr_req, link_up, crs_dv;
  logic [8:0]  tx_active, txfifo_wr, mac_awake;
  logic [2:0]  casc_mult;
  logic [2:0]  vl [9];
  logic [7:0]  a;
  int          num_errors, checks, k, d;
  sfp_axi_req_t rq;
  sfp_axi_rsp_t rs;
  sfp_pkt_t     pk;
  sfp_dec_t     dec;
  sfp_policy sfp_policy_inst (.*, .ce(ce), .axi_req(rq), .axi_rsp(rs),
    .pkt_valid(pv), .pkt(pk));
  sfp_phy_model sfp_phy_model_inst (.*);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] ad, input logic [31:0] v,
                    input logic [1:0] e);
    logic       aw_ok, w_ok, b_ok;
    logic [1:0] br;
    b_ok = 1'b0;
    @(posedge aclk);
    rq.awaddr <= {24'h0, ad};
    rq.wdata <= v;
    rq.wstrb <= 4'hF;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    for (int i = 0; i < 99 && !b_ok; i++) begin
      // Look where the answer has settled, act after the next rising edge
      @(negedge aclk);
      aw_ok = rs.awready;
      w_ok  = rs.wready;
      b_ok  = rs.bvalid;
      br    = rs.bresp;
      @(posedge aclk);
      if (aw_ok) rq.awvalid <= 1'b0;
      if (w_ok) rq.wvalid <= 1'b0;
    end
    rq.bready <= 1'b0;
    cmp("bvalid", 32'h1, 32'(b_ok));
    cmp("bresp", 32'(e), 32'(br));
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] v,
                    input logic [1:0] e);
    logic        ar_ok, r_ok;
    logic [31:0] rv;
    logic [1:0]  rr;
    r_ok = 1'b0;
    @(posedge aclk);
    rq.araddr <= {24'h0, ad};
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    for (int i = 0; i < 99 && !r_ok; i++) begin
      @(negedge aclk);
      ar_ok = rs.arready;
      r_ok  = rs.rvalid;
      rv    = rs.rdata;
      rr    = rs.rresp;
      @(posedge aclk);
      if (ar_ok) rq.arvalid <= 1'b0;
    end
    rq.rready <= 1'b0;
    cmp("rvalid", 32'h1, 32'(r_ok));
    cmp("rdata", v, rv);
    cmp("rresp", 32'(e), 32'(rr));
  endtask : rd
  function automatic logic [8:0] ref_mask(input int s, input logic [47:0] h);
    logic [8:0] m;
    logic       p1;
    for (int p = 0; p < 9; p++) m[p] = (p != s) && (vl[p] === vl[s]);
    if (trunk_en && s < 2) m[1:0] = 2'h0;
    p1 = (link_cfg[1:0] == 2'h3) ? ^h : (link_cfg[1:0] != 2'h1);
    if (trunk_en && m[1:0] != 2'h0) m[1:0] = p1 ? 2'h2 : 2'h1;
    if (mirror_select_pins[2:0] != MIR_OFF && (mirror_select_pins[3] ?
        s == int'(mirror_select_pins[2:0]) : m[mirror_select_pins[2:0]]))
      m[7] = 1'b1;
    return m;
  endfunction : ref_mask
  task automatic send(input int s, input logic [47:0] sm, input logic lh,
                      input logic [3:0] lp);
    logic     ok;
    sfp_dec_t dq;
    ok = 1'b0;
    @(posedge aclk);
    pv <= 1'b1;
    pk <= '{s[3:0], sm, 48'h5, lp, lh};
    for (int i = 0; i < 99 && !ok; i++) begin
      @(negedge aclk);
      ok = pkt_ready;
      @(posedge aclk);
    end
    pv <= 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 99 && !ok; i++) begin
      // Head is caught before the sink pops it at the next rising edge
      @(negedge aclk);
      ok = dec_valid && dec_ready;
      dq = dec;
      @(posedge aclk);
    end
    cmp("dec_valid", 32'h1, 32'(ok));
    cmp("fwd_mask", 32'(ref_mask(s, sm ^ 48'h5)), 32'(dq.fwd_mask));
    cmp("relearn", 32'(trunk_en && lh && lp > 1 && s < 2), 32'(dq.relearn));
    cmp("relearn_port", 32'(s), 32'(dq.relearn_port));
  endtask : send
  task give_verdict;
    $display("errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial begin
    {aresetn, trunk_en, stall, pv, rate_straps} = '0;
    ce = 1'b1;
    {link_cfg, rx_req, tx_req, wr_req} = '0;
    rq = '0;
    pk = '0;
    mirror_select_pins = 4'hF;
    for (int st = 0; st < 4; st++) begin
      @(posedge aclk);
      rate_straps <= 2'(st);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      cmp("casc_mult", 32'(4 - st), 32'(casc_mult));
    end
    // Bench clock too slow for wire speed above 200 Mbps
    tx_req <= 9'h010;
    rd(OFS_IDLE, 32'(IDLE_RST), RESP_OKAY);
    rd(8'h60, 32'h0, RESP_SLVERR);
    wr(8'h60, 32'h1, RESP_SLVERR);
    wr(OFS_RATE, 32'h0, RESP_OKAY);
    rd(OFS_RATE, 32'h1, RESP_OKAY);
    rd(OFS_MIRROR, 32'h1F, RESP_OKAY);
    for (k = 0; k < 9; k++) begin
      vl[k] = (k == 8) ? 3'h7 : (k < 2) ? 3'h1 : 3'(k % 3);
      a = OFS_PORT0 + 8'(4 * k);
      rd(a, 32'(PORT_CTRL_RST), RESP_OKAY);
      // Other control bits left alike on every port
      wr(a, 32'(vl[k]) << VID_LSB, RESP_OKAY);
      rd(a, 32'(vl[k]) << VID_LSB, RESP_OKAY);
    end
    link_cfg <= '1;
    wr(OFS_IDLE, 32'h8, RESP_OKAY);
    for (k = 0; k < 32; k++) begin
      trunk_en <= k[4];
      mirror_select_pins <= k[3:0];
      link_cfg[1:0] <= k[4] ? k[1:0] : 2'h3;
      repeat (2) @(posedge aclk);
      send(0, 48'(k), k[0], 4'(k[2:0]));
      send(4, 48'(k * 3), 1'b1, 4'h1);
      send(5, 48'h9, 1'b0, 4'h0);
      send(8, 48'h2, 1'b0, 4'h0);
    end
    stall <= 1'b1;
    pk <= '{4'h2, 48'h6, 48'h5, 4'h0, 1'b0};
    @(posedge aclk);
    pv <= 1'b1;
    d = 0;
    repeat (20) begin
      @(negedge aclk);
      if (pkt_ready) d++;
      @(posedge aclk);
    end
    pv <= 1'b0;
    cmp("pushed", 32'd16, 32'(d));
    cmp("pkt_ready", 32'h0, 32'(pkt_ready));
    stall <= 1'b0;
    d = 0;
    repeat (20) begin
      @(negedge aclk);
      if (dec_valid && dec_ready) begin
        d++;
        cmp("fwd_mask", 32'(ref_mask(2, 48'h3)), 32'(dec.fwd_mask));
      end
      @(posedge aclk);
    end
    cmp("drained", 32'd16, 32'(d));
    cmp("dec_valid", 32'h0, 32'(dec_valid));
    // Enable low must shut the lookup side
    ce <= 1'b0;
    repeat (2) @(posedge aclk);
    cmp("pkt_ready", 32'h0, 32'(pkt_ready));
    ce <= 1'b1;
    cmp("mac_awake", 32'h010, 32'(mac_awake));
    rd(OFS_SLEEP, 32'h1EF, RESP_OKAY);
    rd(OFS_STATUS, 32'h1FF, RESP_OKAY);
    rx_req <= 9'h008;
    wr_req <= 9'h040;
    @(posedge aclk);
    wr_req <= '0;
    @(posedge aclk);
    cmp("mac_awake", 32'h058, 32'(mac_awake));
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    give_verdict;
  end
endmodule : sfp_policy_tb_top
